/* srpc_pkg.sv */
/*
  Package for the string repeat prefix control block: prefix and primitive
  encodings, count width, sequencer states.
  Assumes a single core clock and synchronous handshakes with the datapath.
*/
// Overview of operation
// - Unconditional prefix on move or store loops until the count is zero.
// - Test count before each pass; service interrupt, run primitive, decrement.
// - Equal/zero prefix is the same byte as the unconditional prefix.
// - Equal prefix on compare/scan continues only if zero flag set.
// - Unequal prefix on compare/scan ends when zero flag set.
// - Zero flag tested only after a primitive ran, never before.
// - Zero-flag exit only for compare or scan, byte or word.
package srpc_pkg;
  localparam int unsigned COUNT_W = 16;

  // Prefix byte selects polarity; the equal and plain forms share one code
  localparam logic PREFIX_WHILE_EQUAL   = 1'h1;
  localparam logic PREFIX_WHILE_UNEQUAL = 1'h0;

  typedef enum logic [2:0] {
    SRPC_PRIM_MOVE_BYTE,
    SRPC_PRIM_MOVE_WORD,
    SRPC_PRIM_STORE_BYTE,
    SRPC_PRIM_STORE_WORD,
    SRPC_PRIM_COMPARE_BYTE,
    SRPC_PRIM_COMPARE_WORD,
    SRPC_PRIM_SCAN_BYTE,
    SRPC_PRIM_SCAN_WORD
  } srpc_prim_e;

  typedef enum logic [2:0] {
    SRPC_IDLE,
    SRPC_TEST,
    SRPC_SERVICE,
    SRPC_EXEC,
    SRPC_DECR
  } srpc_state_e;
endpackage

/* srpc_dp_if.sv */
/*
  Interface between the sequencer and its exit-decision helper.
  Assumes both ends on the core clock.
*/
interface srpc_dp_if;
  import srpc_pkg::*;
  logic       prefix_equal;
  srpc_prim_e prim;
  logic       zero_flag;
  logic       exit_now;
  modport seq  (output prefix_equal, output prim, output zero_flag, input exit_now);
  modport exitd(input prefix_equal, input prim, input zero_flag, output exit_now);
endinterface

/* srpc_exit_decide.sv */
/*
  Combinational zero-flag exit decision after one executed pass.
  Assumes the flag given is the one the primitive just posted.
*/
module srpc_exit_decide (
  srpc_dp_if.exitd dp
);
  import srpc_pkg::*;
  logic is_cmp_scan;
  always_comb begin
    is_cmp_scan = (dp.prim == SRPC_PRIM_COMPARE_BYTE) || (dp.prim == SRPC_PRIM_COMPARE_WORD) ||
                  (dp.prim == SRPC_PRIM_SCAN_BYTE) || (dp.prim == SRPC_PRIM_SCAN_WORD);
    if (dp.prefix_equal == PREFIX_WHILE_EQUAL) begin
      dp.exit_now = is_cmp_scan && !dp.zero_flag;
    end else begin
      dp.exit_now = is_cmp_scan && dp.zero_flag;
    end
  end
endmodule

/* srpc_top.sv */
/*
  Sequencer for a repeated string instruction: checks the count, services
  interrupts between passes, runs one primitive per pass, decrements count.
  Assumes prefix decode supplies a start pulse with prefix/primitive/count,
  and the string datapath answers each exec request with a done pulse.
*/
module srpc_top (
  input  wire logic                         clk_sys_i,
  input  wire logic                         rstn_i,
  input  wire logic                         start_i,
  input  wire logic                         prefix_equal_i,
  input  wire srpc_pkg::srpc_prim_e         prim_i,
  input  wire logic [srpc_pkg::COUNT_W-1:0] count_i,
  input  wire logic                         irq_pending_i,
  input  wire logic                         irq_done_i,
  input  wire logic                         prim_done_i,
  input  wire logic                         zero_flag_i,
  output logic                              busy_o,
  output logic                              irq_req_o,
  output logic                              exec_o,
  output logic [srpc_pkg::COUNT_W-1:0]      count_o,
  output logic                              finish_o
);
  import srpc_pkg::*;

  // Exit helper sees captured prefix and primitive plus the live flag
  srpc_dp_if dp ();

  // Sequencer state
  srpc_state_e        state_reg;
  srpc_state_e        state_next;
  // Operands captured with the start pulse
  logic               pfx_reg;
  logic               pfx_next;
  srpc_prim_e         prim_reg;
  srpc_prim_e         prim_next;
  // Passes still to run
  logic [COUNT_W-1:0] cnt_reg;
  logic [COUNT_W-1:0] cnt_next;
  // Early-exit verdict of the last pass
  logic               exit_reg;
  logic               exit_next;
  // Registered outputs
  logic               irq_reg;
  logic               irq_next;
  logic               exec_reg;
  logic               exec_next;
  logic               fin_reg;
  logic               fin_next;
  logic               busy_reg;
  logic               busy_next;
  // Events decoded once, shared by every group
  logic               take_start;
  logic               go_irq;
  logic               go_exec;
  logic               pass_over;
  logic               loop_end;

  // Flag only meaningful once a primitive has completed
  assign dp.prefix_equal = pfx_reg;
  assign dp.prim         = prim_reg;
  assign dp.zero_flag    = zero_flag_i;

  srpc_exit_decide u_srpc_exit_decide (
    .dp (dp)
  );

  // One decode of the current state keeps all groups in step
  always_comb begin
    take_start = 1'h0;
    go_irq     = 1'h0;
    go_exec    = 1'h0;
    pass_over  = 1'h0;
    loop_end   = 1'h0;
    unique case (state_reg)
      SRPC_IDLE: begin
        take_start = start_i;
      end
      SRPC_TEST: begin
        if (cnt_reg == '0 || exit_reg) begin
          loop_end = 1'h1;
        end else if (irq_pending_i) begin
          go_irq = 1'h1;
        end else begin
          go_exec = 1'h1;
        end
      end
      SRPC_SERVICE: begin
        go_exec = irq_done_i;
      end
      SRPC_EXEC: begin
        pass_over = prim_done_i;
      end
      SRPC_DECR: begin
        loop_end = 1'h0;
      end
      default: begin
        loop_end = 1'h0;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SRPC_IDLE: begin
        if (take_start) begin
          state_next = SRPC_TEST;
        end
      end
      SRPC_TEST: begin
        if (loop_end) begin
          state_next = SRPC_IDLE;
        end else if (go_irq) begin
          state_next = SRPC_SERVICE;
        end else begin
          state_next = SRPC_EXEC;
        end
      end
      SRPC_SERVICE: begin
        if (go_exec) begin
          state_next = SRPC_EXEC;
        end
      end
      SRPC_EXEC: begin
        if (pass_over) begin
          state_next = SRPC_DECR;
        end
      end
      SRPC_DECR: begin
        state_next = SRPC_TEST;
      end
      default: begin
        state_next = SRPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= SRPC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    pfx_next  = pfx_reg;
    prim_next = prim_reg;
    if (take_start) begin
      // one prefix code, meaning by primitive
      pfx_next  = prefix_equal_i;
      prim_next = prim_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pfx_reg  <= 1'h0;
      prim_reg <= SRPC_PRIM_MOVE_BYTE;
    end else begin
      pfx_reg  <= pfx_next;
      prim_reg <= prim_next;
    end
  end

  always_comb begin
    cnt_next = cnt_reg;
    if (take_start) begin
      cnt_next = count_i;
    end else if (state_reg == SRPC_DECR) begin
      cnt_next = cnt_reg - COUNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_comb begin
    exit_next = exit_reg;
    if (take_start) begin
      exit_next = 1'h0;
    end else if (pass_over) begin
      exit_next = dp.exit_now;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exit_reg <= 1'h0;
    end else begin
      exit_reg <= exit_next;
    end
  end

  // Pulses last one cycle; busy drops with the finish pulse
  always_comb begin
    irq_next  = go_irq;
    exec_next = go_exec;
    fin_next  = loop_end;
    busy_next = (state_next != SRPC_IDLE);
  end

  // no flag outputs; flags come only from the datapath
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_reg  <= 1'h0;
      exec_reg <= 1'h0;
      fin_reg  <= 1'h0;
      busy_reg <= 1'h0;
    end else begin
      irq_reg  <= irq_next;
      exec_reg <= exec_next;
      fin_reg  <= fin_next;
      busy_reg <= busy_next;
    end
  end

  assign busy_o    = busy_reg;
  assign irq_req_o = irq_reg;
  assign exec_o    = exec_reg;
  assign count_o   = cnt_reg;
  assign finish_o  = fin_reg;
endmodule

/* srpc_asserts.sv */
/* Port checker for the string repeat sequencer.
   Assumes it is bound to every srpc_top instance. */
module srpc_asserts (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        start_i,
  input wire logic [15:0] count_i,
  input wire logic        irq_pending_i,
  input wire logic        prim_done_i,
  input wire logic        busy_o,
  input wire logic        irq_req_o,
  input wire logic        exec_o,
  input wire logic [15:0] count_o,
  input wire logic        finish_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence s_take; start_i && !busy_o; endsequence
  sequence s_empty_end; !exec_o ##1 finish_o && !exec_o; endsequence
  property p_busy; s_take |=> busy_o; endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_zero; (s_take and (count_i == 16'h0)) |=> s_empty_end; endproperty
  a_zero: assert property (p_zero) else $error("zero count ran");
  property p_first; (s_take and (count_i != 16'h0 && !irq_pending_i)) |=> ##1 exec_o; endproperty
  a_first: assert property (p_first) else $error("first pass missing");
  property p_irq; (s_take and (count_i != 16'h0 && irq_pending_i)) |=> ##1 irq_req_o && !exec_o; endproperty
  a_irq: assert property (p_irq) else $error("interrupt not first");
  property p_dec; prim_done_i && busy_o |-> ##2 count_o == $past(count_o, 2) - 16'h1; endproperty
  a_dec: assert property (p_dec) else $error("count not decremented");
  property p_hold; busy_o && $past(busy_o) && $changed(count_o) |-> $past(prim_done_i, 2); endproperty
  a_hold: assert property (p_hold) else $error("count moved alone");
  property p_nozero; busy_o && count_o == 16'h0 |-> !exec_o; endproperty
  a_nozero: assert property (p_nozero) else $error("exec at zero");
  property p_fin; finish_o |-> !busy_o && !exec_o; endproperty
  a_fin: assert property (p_fin) else $error("finish while busy");
endmodule
bind srpc_top srpc_asserts u_srpc_asserts (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .start_i(start_i),
  .count_i(count_i), .irq_pending_i(irq_pending_i), .prim_done_i(prim_done_i), .busy_o(busy_o),
  .irq_req_o(irq_req_o), .exec_o(exec_o), .count_o(count_o), .finish_o(finish_o));

/* tb_srpc_top.sv */
/* Testbench for srpc_top acting as decode, datapath and interrupt logic.
   Assumes package, interface and checker compiled first. */
module tb_srpc_top;
  timeunit 1ns;
  timeprecision 100ps;
  import srpc_pkg::*;
  logic clk_sys_i, rstn_i, start_i, pe, ip, idn, pd, zf, busy, irq, ex, fin;
  srpc_prim_e pr;
  logic [15:0] ci, co;
  int n_fail = 0, compares = 0;
  srpc_top u_srpc_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .start_i(start_i), .prefix_equal_i(pe),
    .prim_i(pr), .count_i(ci), .irq_pending_i(ip), .irq_done_i(idn), .prim_done_i(pd), .zero_flag_i(zf),
    .busy_o(busy), .irq_req_o(irq), .exec_o(ex), .count_o(co), .finish_o(fin));
  initial begin
    clk_sys_i = 0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Flag starts inverted so a stale value cannot end the loop
  task run(input logic e, input srpc_prim_e p, input logic [15:0] c, input logic z, input logic q, input int np);
    int n;
    int ni;
    n = 0;
    ni = 0;
    pe = e;
    pr = p;
    ci = c;
    zf = ~z;
    ip = q;
    start_i = 1'h1;
    @(posedge clk_sys_i) #1 start_i = 1'h0;
    repeat (100) begin
      @(posedge clk_sys_i) #1 pd = 1'h0;
      idn = 1'h0;
      if (fin === 1'h1) break;
      if (irq === 1'h1) begin
        idn = 1'h1;
        ip = 1'h0;
        ni++;
      end
      if (ex === 1'h1) begin
        pd = 1'h1;
        zf = z;
        n++;
      end
    end
    chk(fin, 32'h1);
    chk(busy, 32'h0);
    chk(n, np);
    chk(ni, q);
    chk(co, c - np[15:0]);
    $display("test done passes=%0d", n);
  endtask
  // Reset in mid-pass must clear every output
  task t_reset;
    pe = 1'h1;
    pr = SRPC_PRIM_MOVE_BYTE;
    ci = 16'h5;
    ip = 1'h0;
    start_i = 1'h1;
    @(posedge clk_sys_i) #1 start_i = 1'h0;
    repeat (2) @(posedge clk_sys_i);
    #1 rstn_i = 1'h0;
    @(posedge clk_sys_i) #1;
    chk({busy, irq, ex, fin, co}, 32'h0);
    rstn_i = 1'h1;
    $display("test done reset");
  endtask
  task t_zero;
    run(1'h1, SRPC_PRIM_MOVE_BYTE, 16'h0, 1'h0, 1'h0, 32'h0);
  endtask
  task t_move;
    run(1'h1, SRPC_PRIM_MOVE_WORD, 16'h3, 1'h0, 1'h0, 32'h3);
  endtask
  task t_store;
    run(1'h0, SRPC_PRIM_STORE_BYTE, 16'h2, 1'h1, 1'h0, 32'h2);
  endtask
  task t_store_word;
    run(1'h0, SRPC_PRIM_STORE_WORD, 16'h1, 1'h1, 1'h1, 32'h1);
  endtask
  task t_cmp_ex;
    run(1'h1, SRPC_PRIM_COMPARE_BYTE, 16'h4, 1'h0, 1'h0, 32'h1);
  endtask
  task t_cmp_go;
    run(1'h1, SRPC_PRIM_COMPARE_WORD, 16'h2, 1'h1, 1'h0, 32'h2);
  endtask
  task t_scan_ex;
    run(1'h0, SRPC_PRIM_SCAN_WORD, 16'h4, 1'h1, 1'h0, 32'h1);
  endtask
  task t_scan_go;
    run(1'h0, SRPC_PRIM_SCAN_BYTE, 16'h2, 1'h0, 1'h1, 32'h2);
  endtask
  initial begin
    rstn_i = 1'h0;
    start_i = 1'h0;
    pe = 1'h0;
    pr = SRPC_PRIM_MOVE_BYTE;
    ci = 16'h0;
    ip = 1'h0;
    idn = 1'h0;
    pd = 1'h0;
    zf = 1'h0;
    repeat (16) @(posedge clk_sys_i);
    #1 rstn_i = 1'h1;
    t_zero;
    t_move;
    t_store;
    t_store_word;
    t_cmp_ex;
    t_cmp_go;
    t_reset;
    t_scan_ex;
    t_scan_go;
    wrap_up;
  end
  initial begin
    #20000;
    n_fail++;
    wrap_up;
  end
endmodule
